// >>> lcdcd_regs.svh
// Command prefixes, field positions, reset values and timing counts of the
// LCD command decoder. Included by the decoder core; definitions only.
`ifndef LCDCD_REGS_SVH
`define LCDCD_REGS_SVH

// Command prefixes and the bit position where each prefix starts
`define LCDCD_FRAME_PFX      3'b011
`define LCDCD_FRAME_POS      5
`define LCDCD_BANK_PFX       6'b000010
`define LCDCD_BANK_POS       2
`define LCDCD_INV_PFX        6'b110101
`define LCDCD_INV_POS        2
`define LCDCD_FILT_PFX       7'b1101001
`define LCDCD_FILT_POS       1
`define LCDCD_PTR_PFX        2'b10
`define LCDCD_PTR_POS        6

// Field positions inside the command byte
`define LCDCD_WBANK_BIT      1
`define LCDCD_DBANK_BIT      0
`define LCDCD_INV_BIT        1
`define LCDCD_FILT_BIT       0

// Reset values and the last RAM pointer address
`define LCDCD_FRAME_CODE_RST 5'h0e
`define LCDCD_PTR_RST        6'h00
`define LCDCD_PTR_MAX        6'h2d

// Timing: system clock rate and clock-to-frame division
`define LCDCD_CLK_HZ         125000000
`define LCDCD_FRAME_DIV      48
`define LCDCD_LINE_DIV       12

`endif

// >>> lcdcd_pkg.sv
// Types shared by the LCD command decoder.
// Assumes the constants header is included by the design files.
package lcdcd_pkg;

  // Drive-scheme inversion choice
  typedef enum logic {
    LCDCD_INV_LINE  = 1'b0,
    LCDCD_INV_FRAME = 1'b1
  } lcdcd_inv_t;

  typedef logic [7:0] lcdcd_byte_t;

endpackage

// >>> lcdcd_core.sv
// LCD segment driver command decoder: frame rate, bank select, RAM data,
// temperature readout, inversion mode and temperature filter.
// Assumes a serial front end on clk_sys that delivers one byte per strobe
// together with the control byte's RAM-data flag.
`timescale 1ns/10ps
`include "lcdcd_regs.svh"

// Functional notes
// - Command 011xxxxx loads the five-bit frame rate code.
// - Each code maps to a frame and clock frequency; codes 11000 up give 300 Hz.
// - Frame frequency is a fixed division of internal or external clock.
// - Frame rate code resets to 01110, 200 Hz frame and 9600 Hz clock.
// - Internal clock driven out on the pin has the tabulated duty ratio.
// - Command 000010xx sets write bank (bit 1) and display bank (bit 0).
// - Two RAM banks; write one while the display reads the other.
// - With RAM-data flag set, each byte is stored at the pointer.
// - Temperature read returns one eight-bit temperature byte.
// - Command 110101x0 picks line (0, default) or frame (1) inversion.
// - Drive waveforms invert on alternate lines or frames to cancel DC.
// - Frame inversion balances DC over a pair of frames.
// - Command 1101001x sets filter enable; off means raw value used at once.
// - Command 10xxxxxx loads the RAM pointer, addresses 0 to 45.
// - Clock output enable drives the pin with the internal oscillator only; cleared, or external clock, leaves pin floating.
module lcdcd_core
  import lcdcd_pkg::*;
#(
  parameter int RAM_DEPTH = 46
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        cmd_valid,
  input  wire logic        ram_data_flag,
  input  wire logic        clock_out_enable,
  input  wire logic        osc_external,
  input  wire logic        clk_pin_in,
  input  wire logic [7:0]  temp_raw,
  input  wire logic        temp_sample,
  input  wire logic        temp_read,
  input  wire logic [5:0]  disp_addr,
  output logic             clk_pin_out,
  output logic             clk_pin_oe_n,
  output logic [4:0]       frame_code,
  output logic             write_bank_sel,
  output logic             display_bank_sel,
  output logic [5:0]       ram_ptr,
  output logic [7:0]       disp_data,
  output logic [7:0]       temperature_value,
  output logic [7:0]       temp_rd_data,
  output logic             temp_rd_valid,
  output lcdcd_inv_t       inversion_scheme,
  output logic             temp_filter_on,
  output logic             frame_tick,
  output logic             drive_polarity,
  output logic             frame_parity
);

  // Output clock frequency in Hz for a frame rate code
  function automatic int unsigned clk_hz(input logic [4:0] c);
    case (c)
      5'h00: clk_hz = 2880;
      5'h01: clk_hz = 3360;
      5'h02: clk_hz = 3840;
      5'h03: clk_hz = 4368;
      5'h04: clk_hz = 4800;
      5'h05: clk_hz = 5232;
      5'h06: clk_hz = 5760;
      5'h07: clk_hz = 6226;
      5'h08: clk_hz = 6778;
      5'h09: clk_hz = 7200;
      5'h0a: clk_hz = 7680;
      5'h0b: clk_hz = 8227;
      5'h0c: clk_hz = 8534;
      5'h0d: clk_hz = 9216;
      5'h0e: clk_hz = 9600;
      5'h0f: clk_hz = 10018;
      5'h10: clk_hz = 10474;
      5'h11: clk_hz = 10973;
      5'h12: clk_hz = 11520;
      5'h13: clk_hz = 12125;
      5'h14, 5'h15: clk_hz = 12802;
      5'h16, 5'h17: clk_hz = 13555;
      default: clk_hz = 14400;
    endcase
  endfunction

  // Percent of the clock period spent high for a frame rate code
  function automatic int unsigned duty_hi(input logic [4:0] c);
    case (c)
      5'h00, 5'h06, 5'h12: duty_hi = 20;
      5'h01: duty_hi = 7;
      5'h02, 5'h0a: duty_hi = 47;
      5'h03: duty_hi = 40;
      5'h04, 5'h0e: duty_hi = 33;
      5'h05, 5'h10: duty_hi = 27;
      5'h07: duty_hi = 13;
      5'h08, 5'h16, 5'h17: duty_hi = 5;
      5'h0b: duty_hi = 43;
      5'h0c: duty_hi = 41;
      5'h0d: duty_hi = 36;
      5'h0f: duty_hi = 30;
      5'h11: duty_hi = 23;
      5'h13: duty_hi = 16;
      5'h14, 5'h15: duty_hi = 10;
      default: duty_hi = 50;
    endcase
  endfunction

  logic [4:0]  frame_code_q;
  logic        wbank_q;
  logic        dbank_q;
  logic [5:0]  ptr_q;
  lcdcd_inv_t  inv_q;
  logic        filt_on_q;
  logic        cmd_take;
  logic        data_take;
  logic [7:0]  ram_q [2][RAM_DEPTH];
  logic [16:0] osc_cnt_q;
  logic [16:0] period;
  logic [16:0] high_cnt;
  logic        osc_q;
  logic        int_rise;
  logic [2:0]  ext_sync_q;
  logic        ext_lvl_q;
  logic        ext_rise;
  logic        clk_edge;
  logic [5:0]  div_cnt_q;
  logic        frame_tick_q;
  logic        pol_q;
  logic        parity_q;
  logic [7:0]  filt_q;
  logic [7:0]  temp_q;
  logic [7:0]  rd_data_q;
  logic        rd_valid_q;
  logic [7:0]  disp_q;
  logic        pin_out_q;
  logic        pin_oe_n_q;

  // Command bytes versus RAM data bytes
  assign cmd_take  = cmd_valid & ~ram_data_flag;
  assign data_take = cmd_valid & ram_data_flag;

  // Frame rate code
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      frame_code_q <= `LCDCD_FRAME_CODE_RST;
    end else if (cmd_take && cmd_byte[7:`LCDCD_FRAME_POS] == `LCDCD_FRAME_PFX) begin
      frame_code_q <= cmd_byte[4:0];
    end
  end

  // Bank selectors
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wbank_q <= 1'b0;
      dbank_q <= 1'b0;
    end else if (cmd_take && cmd_byte[7:`LCDCD_BANK_POS] == `LCDCD_BANK_PFX) begin
      wbank_q <= cmd_byte[`LCDCD_WBANK_BIT];
      dbank_q <= cmd_byte[`LCDCD_DBANK_BIT];
    end
  end

  // Inversion mode and temperature filter switches
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      inv_q     <= LCDCD_INV_LINE;
      filt_on_q <= 1'b0;
    end else if (cmd_take) begin
      if (cmd_byte[7:`LCDCD_INV_POS] == `LCDCD_INV_PFX && !cmd_byte[0]) begin
        inv_q <= lcdcd_inv_t'(cmd_byte[`LCDCD_INV_BIT]);
      end
      if (cmd_byte[7:`LCDCD_FILT_POS] == `LCDCD_FILT_PFX) begin
        filt_on_q <= cmd_byte[`LCDCD_FILT_BIT];
      end
    end
  end

  // Data pointer: load in range, advance after each data byte, wrap past 45
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= `LCDCD_PTR_RST;
    end else if (cmd_take && cmd_byte[7:`LCDCD_PTR_POS] == `LCDCD_PTR_PFX) begin
      if (cmd_byte[5:0] <= `LCDCD_PTR_MAX) begin
        ptr_q <= cmd_byte[5:0];
      end
    end else if (data_take) begin
      ptr_q <= (ptr_q >= `LCDCD_PTR_MAX) ? `LCDCD_PTR_RST : ptr_q + 6'h01;
    end
  end

  // Two banks: write side and display side pick banks independently
  always_ff @(posedge clk_sys) begin
    if (data_take && ptr_q <= `LCDCD_PTR_MAX) begin
      ram_q[wbank_q][ptr_q] <= cmd_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      disp_q <= 8'h00;
    end else if (disp_addr <= `LCDCD_PTR_MAX) begin
      disp_q <= ram_q[dbank_q][disp_addr];
    end else begin
      disp_q <= 8'h00;
    end
  end

  // Internal oscillator period and high time for the current code
  assign period   = 17'(`LCDCD_CLK_HZ / clk_hz(frame_code_q));
  assign high_cnt = 17'((32'(period) * duty_hi(frame_code_q)) / 100);
  assign int_rise = (osc_cnt_q == 17'h00000);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      osc_cnt_q <= 17'h00000;
      osc_q     <= 1'b0;
    end else begin
      osc_cnt_q <= (osc_cnt_q >= period - 17'h00001) ? 17'h00000 : osc_cnt_q + 17'h00001;
      osc_q     <= (osc_cnt_q < high_cnt);
    end
  end

  // External clock pin: three flops, edge once the last two agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ext_sync_q <= 3'h0;
      ext_lvl_q  <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], clk_pin_in};
      if (ext_sync_q[1] == ext_sync_q[2]) begin
        ext_lvl_q <= ext_sync_q[2];
      end
    end
  end

  assign ext_rise = (ext_sync_q[1] == ext_sync_q[2]) & ext_sync_q[2] & ~ext_lvl_q;
  assign clk_edge = osc_external ? ext_rise : int_rise;

  // Fixed division to frame rate, line and frame inversion
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q    <= 6'h00;
      frame_tick_q <= 1'b0;
      pol_q        <= 1'b0;
      parity_q     <= 1'b0;
    end else begin
      frame_tick_q <= 1'b0;
      if (clk_edge) begin
        if (div_cnt_q == 6'(`LCDCD_FRAME_DIV - 1)) begin
          div_cnt_q    <= 6'h00;
          frame_tick_q <= 1'b1;
          parity_q     <= ~parity_q;
          if (inv_q == LCDCD_INV_FRAME) begin
            pol_q <= ~pol_q;
          end
        end else begin
          div_cnt_q <= div_cnt_q + 6'h01;
        end
        if (inv_q == LCDCD_INV_LINE && div_cnt_q % 6'(`LCDCD_LINE_DIV) == 6'(`LCDCD_LINE_DIV - 1)) begin
          pol_q <= ~pol_q;
        end
      end
    end
  end

  // Clock pin drive; floating unless enabled with internal oscillator
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_out_q  <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_out_q  <= osc_q;
      pin_oe_n_q <= ~(clock_out_enable & ~osc_external);
    end
  end

  // Temperature filter and readout value
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      filt_q <= 8'h00;
      temp_q <= 8'h00;
    end else begin
      if (temp_sample) begin
        filt_q <= 8'(({1'b0, filt_q} + {1'b0, temp_raw}) >> 1);
      end
      temp_q <= filt_on_q ? filt_q : temp_raw;
    end
  end

  // Temperature read answer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= temp_read;
      if (temp_read) begin
        rd_data_q <= temp_q;
      end
    end
  end

  assign frame_code        = frame_code_q;
  assign write_bank_sel    = wbank_q;
  assign display_bank_sel  = dbank_q;
  assign ram_ptr           = ptr_q;
  assign disp_data         = disp_q;
  assign temperature_value = temp_q;
  assign temp_rd_data      = rd_data_q;
  assign temp_rd_valid     = rd_valid_q;
  assign inversion_scheme  = inv_q;
  assign temp_filter_on    = filt_on_q;
  assign frame_tick        = frame_tick_q;
  assign drive_polarity    = pol_q;
  assign frame_parity      = parity_q;
  assign clk_pin_out       = pin_out_q;
  assign clk_pin_oe_n      = pin_oe_n_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_frame_load: assert property (cmd_take && cmd_byte[7:5] == 3'b011 |=> frame_code_q == $past(cmd_byte[4:0])) else $error("frame code not loaded");
  a_frame_hold: assert property (!(cmd_take && cmd_byte[7:5] == 3'b011) |=> $stable(frame_code_q)) else $error("frame code changed without command");
  a_bank_load: assert property (cmd_take && cmd_byte[7:2] == 6'b000010 |=> wbank_q == $past(cmd_byte[1]) && dbank_q == $past(cmd_byte[0])) else $error("bank select wrong");
  a_inv_load: assert property (cmd_take && cmd_byte[7:2] == 6'b110101 && !cmd_byte[0] |=> inv_q == lcdcd_inv_t'($past(cmd_byte[1]))) else $error("inversion mode wrong");
  a_filt_load: assert property (cmd_take && cmd_byte[7:1] == 7'b1101001 |=> filt_on_q == $past(cmd_byte[0])) else $error("filter enable wrong");
  a_raw_direct: assert property (!filt_on_q |=> temp_q == $past(temp_raw)) else $error("unfiltered value not immediate");
  a_ptr_advance: assert property (data_take && ptr_q < 6'h2d |=> ptr_q == $past(ptr_q) + 6'h01) else $error("pointer did not advance");
  a_ptr_range: assert property (ptr_q <= 6'h2d) else $error("pointer out of range");
  a_ram_store: assert property (data_take && ptr_q <= 6'h2d |=> ram_q[$past(wbank_q)][$past(ptr_q)] == $past(cmd_byte)) else $error("data byte not stored");
  a_rd_answer: assert property (temp_read |=> rd_valid_q && rd_data_q == $past(temp_q)) else $error("temperature read wrong");
  a_pin_float: assert property (!clock_out_enable |=> pin_oe_n_q) else $error("clock pin driven while disabled");
  a_frame_pair: assert property (frame_tick_q && inv_q == LCDCD_INV_FRAME && $past(inv_q) == LCDCD_INV_FRAME |-> pol_q != $past(pol_q, 2)) else $error("frame polarity not alternating");

  c_data_burst: cover property (data_take ##1 data_take ##1 data_take);
  c_frame_tick: cover property (frame_tick_q);
  c_bank_swap: cover property (wbank_q && !dbank_q);
  c_clock_out: cover property (!pin_oe_n_q && osc_q);

endmodule

// >>> lcdcd_host.sv
// Host model: streams command and RAM data bytes, asks for temperature.
// Assumes one bench process calls its tasks; drives on the falling edge.
`timescale 1ns/10ps
module lcdcd_host (
  input  wire logic   clk_sys,
  output logic [7:0]  cmd_byte,
  output logic        cmd_valid,
  output logic        ram_data_flag,
  output logic        temp_read
);
  // Idle bus at time zero
  initial begin
    cmd_byte = 8'h00;
    cmd_valid = 1'b0;
    ram_data_flag = 1'b0;
    temp_read = 1'b0;
  end
  // One byte; valid stays up so calls in a row go back to back
  task automatic send(input logic [7:0] b, input logic f);
    @(negedge clk_sys);
    cmd_byte      <= b;
    ram_data_flag <= f;
    cmd_valid     <= 1'b1;
  endtask
  // Drop valid and scramble the stale byte
  task automatic idle();
    @(negedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_byte  <= ~cmd_byte;
  endtask
  // Zero one bank from address 0, since power-up content is random
  task automatic clear_bank(input logic bank);
    send({6'b000010, bank, bank}, 1'b0);
    send(8'h80, 1'b0);
    for (int i = 0; i < 46; i++) send(8'h00, 1'b1);
    idle();
  endtask
  // Read request for the temperature byte
  task automatic read_temp();
    @(negedge clk_sys);
    temp_read <= 1'b1;
    @(negedge clk_sys);
    temp_read <= 1'b0;
  endtask
endmodule

// >>> test_lcd_driver_cmd_decode_timing.sv
// Self-checking bench for the command decoder core.
// Assumes the host model drives the byte stream; external clock 125 ns.
`timescale 1ns/10ps
module test_lcd_driver_cmd_decode_timing
  import lcdcd_pkg::*;
;
  logic clk_sys = 1'b0, rstn = 1'b0, cmd_valid, ram_data_flag, temp_read;
  logic clock_out_enable = 1'b0, osc_external = 1'b0, clk_pin_in = 1'b0;
  logic temp_sample = 1'b0, clk_pin_out, clk_pin_oe_n, write_bank_sel, display_bank_sel;
  logic temp_rd_valid, temp_filter_on, frame_tick, drive_polarity, frame_parity;
  logic [7:0] cmd_byte, disp_data, temperature_value, temp_rd_data, temp_raw = 8'h00;
  logic [7:0] b, dat [4];
  logic [5:0] disp_addr = 6'h00, ram_ptr;
  logic [4:0] frame_code;
  lcdcd_inv_t inversion_scheme;
  logic [4:0] e_fc = 5'h0e;
  logic [5:0] e_ptr = 6'h00;
  logic e_wb = 1'b0, e_db = 1'b0, e_inv = 1'b0, e_flt = 1'b0, p0, p1;
  logic [7:0] corner [6] = '{8'hae, 8'had, 8'hd7, 8'hd6, 8'hd3, 8'h0b};
  int err_count = 0, n_compared = 0, cyc = 0, hi, lo, per, chg;

  lcdcd_host host (.clk_sys(clk_sys), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
    .ram_data_flag(ram_data_flag), .temp_read(temp_read));
  lcdcd_core DUT (.clk_sys(clk_sys), .rstn(rstn), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
    .ram_data_flag(ram_data_flag), .clock_out_enable(clock_out_enable),
    .osc_external(osc_external), .clk_pin_in(clk_pin_in), .temp_raw(temp_raw),
    .temp_sample(temp_sample), .temp_read(temp_read), .disp_addr(disp_addr),
    .clk_pin_out(clk_pin_out), .clk_pin_oe_n(clk_pin_oe_n), .frame_code(frame_code),
    .write_bank_sel(write_bank_sel), .display_bank_sel(display_bank_sel),
    .ram_ptr(ram_ptr), .disp_data(disp_data), .temperature_value(temperature_value),
    .temp_rd_data(temp_rd_data), .temp_rd_valid(temp_rd_valid),
    .inversion_scheme(inversion_scheme), .temp_filter_on(temp_filter_on),
    .frame_tick(frame_tick), .drive_polarity(drive_polarity), .frame_parity(frame_parity));

  // System clock and free-running external clock of unrelated phase
  always #4 clk_sys = ~clk_sys;
  initial #3 forever #62.5 clk_pin_in = ~clk_pin_in;

  // Verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask
  // Tolerance compare for counted durations
  task automatic near(input string nm, input int e, input int g);
    n_compared++;
    if (g < e - 2 || g > e + 2) begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
    end
  endtask
  // Expected effect of one command byte; prefixes are disjoint
  function automatic void apply(input logic [7:0] c);
    if (c[7:5] == 3'b011) e_fc = c[4:0];
    else if (c[7:2] == 6'b000010) {e_wb, e_db} = c[1:0];
    else if (c[7:2] == 6'b110101 && !c[0]) e_inv = c[1];
    else if (c[7:1] == 7'b1101001) e_flt = c[0];
    else if (c[7:6] == 2'b10 && c[5:0] <= 6'd45) e_ptr = c[5:0];
  endfunction
  task automatic chk_state();
    chk("frame_code", e_fc, frame_code);
    chk("banks", {e_wb, e_db}, {write_bank_sel, display_bank_sel});
    chk("ram_ptr", e_ptr, ram_ptr);
    chk("inversion", e_inv, inversion_scheme);
    chk("filter", e_flt, temp_filter_on);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge clk_sys) disp_addr <= a;
    repeat (2) @(negedge clk_sys);
    chk("disp_data", e, disp_data);
  endtask
  // Two high and low phases of the driven clock, in system cycles; the
  // first may start mid-period after a code change, the second is clean
  task automatic meas_clk();
    while (clk_pin_out !== 1'b0) @(negedge clk_sys);
    while (clk_pin_out !== 1'b1) @(negedge clk_sys);
    repeat (2) begin
      hi = 0;
      lo = 0;
      while (clk_pin_out === 1'b1) begin @(negedge clk_sys); hi++; end
      while (clk_pin_out === 1'b0) begin @(negedge clk_sys); lo++; end
    end
  endtask
  // Cycles and polarity changes between two frame ticks
  task automatic meas_frame();
    logic last;
    while (frame_tick !== 1'b1) @(negedge clk_sys);
    p0 = frame_parity;
    last = drive_polarity;
    per = 0;
    chg = 0;
    do begin
      @(negedge clk_sys);
      per++;
      if (drive_polarity !== last) chg++;
      last = drive_polarity;
    end while (frame_tick !== 1'b1);
    p1 = frame_parity;
  endtask

  initial begin
    void'($urandom(35));
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    chk_state();
    chk("oe_n", 1, clk_pin_oe_n);
    // Every frame code, refused and edge bytes, then random bytes
    for (int i = 0; i < 188; i++) begin
      b = 8'(i < 32 ? 8'h60 | i : i < 38 ? corner[i-32] : 8'($urandom));
      host.send(b, 1'b0);
      host.idle();
      apply(b);
      chk_state();
    end
    host.clear_bank(1'b0);
    host.clear_bank(1'b1);
    // Write bank 1 while bank 0 is shown, back to back
    host.send(8'h0a, 1'b0);
    host.send(8'h85, 1'b0);
    for (int i = 0; i < 4; i++) begin
      dat[i] = 8'($urandom);
      host.send(dat[i], 1'b1);
    end
    host.idle();
    chk("ram_ptr", 9, ram_ptr);
    rd(6'd5, 8'h00);
    host.send(8'h0b, 1'b0);
    host.idle();
    for (int i = 0; i < 4; i++) rd(6'(5 + i), dat[i]);
    // Pointer wraps past the last address
    host.send(8'had, 1'b0);
    host.send(8'h3c, 1'b1);
    host.send(8'hc3, 1'b1);
    host.idle();
    chk("ram_ptr", 1, ram_ptr);
    rd(6'd45, 8'h3c);
    rd(6'd0, 8'hc3);
    rd(6'd63, 8'h00);
    // Unfiltered temperature and its readout
    host.send(8'hd2, 1'b0);
    host.idle();
    @(negedge clk_sys) temp_raw <= 8'($urandom);
    repeat (2) @(negedge clk_sys);
    chk("temperature_value", temp_raw, temperature_value);
    host.read_temp();
    for (int i = 0; i < 3 && temp_rd_valid !== 1'b1; i++) @(negedge clk_sys);
    chk("temp_rd_data", {1'b1, temp_raw}, {temp_rd_valid, temp_rd_data});
    @(negedge clk_sys) temp_sample <= 1'b1;
    @(negedge clk_sys) temp_sample <= 1'b0;
    // Filter on: first sample averages with the cleared filter value
    host.send(8'hd3, 1'b0);
    host.idle();
    @(negedge clk_sys);
    chk("filtered temperature", {1'b0, temp_raw[7:1]}, temperature_value);
    // Frames timed by the external clock, line then frame inversion
    osc_external = 1'b1;
    clock_out_enable = 1'b1;
    for (int m = 0; m < 2; m++) begin
      host.send(m ? 8'hd6 : 8'hd4, 1'b0);
      host.idle();
      meas_frame();
      meas_frame();
      near("frame cycles", 750, per);
      chk("polarity changes", m ? 1 : 4, chg);
      chk("parity flip", 1, p0 ^ p1);
    end
    chk("oe_n", 1, clk_pin_oe_n);
    // Internal clock on the pin, two codes of known duty
    osc_external = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("oe_n", 0, clk_pin_oe_n);
    for (int m = 0; m < 2; m++) begin
      host.send(m ? 8'h78 : 8'h69, 1'b0);
      host.idle();
      meas_clk();
      near("clk period", 125000000 / (m ? 14400 : 7200), hi + lo);
      near("clk high", 125000000 / (m ? 14400 : 7200) / 2, hi);
    end
    clock_out_enable = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("oe_n", 1, clk_pin_oe_n);
    end_of_test();
  end
endmodule
